//--- rtl/scs_map.vh
`ifndef SCS_MAP_VH
`define SCS_MAP_VH
// Calibration intervals in link clock cycles.
`define SCS_CAL_BASE 12'h400
`define SCS_CAL_ENH 12'h800
// Impedance code: ohms, limits and divisor of the reference resistor.
`define SCS_Z_MIN 8'h23
`define SCS_Z_MAX 8'h46
`define SCS_Z_DIV 8'h05
// Read latency in half cycles of the link clock.
`define SCS_LAT_BASE 3'h3
`define SCS_LAT_ENH_A 3'h4
`define SCS_LAT_ENH_B 3'h5
// The pipeline tap that feeds the output lies one half cycle before the launch.
`define SCS_LAT_OFS 3'h1
// PLL lock time in link clock cycles.
`define SCS_LOCK_CYC 8'h10
`endif

//--- rtl/scs_sync.v
`default_nettype none
// Two flip-flop synchroniser for a bus of levels.
module scs_sync #(
   parameter W = 1
) (
   input wire mclk_i,
   input wire arst_n_i,
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
      end
   end
   assign q_o = s2_reg;
endmodule // scs_sync
`default_nettype wire

//--- rtl/scs_clocking.v
// Behaviour
// [RULE1] Recalibrate impedance every 1024 or 2048 cycles
// [RULE2] Impedance is reference resistor over five
// [RULE3] Sample inputs on rising clock edges only
// [RULE4] Controller centres complement clock rising edge
// [RULE5] Unused output clock pair held high
// [RULE6] Output clocks time read data when driven
// [RULE7] Echo clocks edge aligned with data
// [RULE8] Echo clocks regenerated from internal PLL
// [RULE9] Controller delays echo clocks ninety degrees
// [RULE10] Input clock capture only up to 167 MHz
// [RULE11] Output clock capture only up to 200 MHz
// [RULE12] PLL held off while disable input low
// [RULE13] Controller raises disable late, waits 20 us
// [RULE14] Tied high: wait stable clock plus 20 us
// [RULE15] Read latency 1.5, 2.0 or 2.5 cycles
// [RULE16] Controller counts wait, blocks commands
`default_nettype none
`include "scs_map.vh"
module scs_clocking (
   // Clock and reset.
   input wire mclk_i,
   input wire arst_n_i,
   // Link clocks and PLL control from the controller.
   input wire kclk_i,
   input wire kclk_n_i,
   input wire oclk_i,
   input wire oclk_n_i,
   input wire pll_disable_n_i,
   // Variant straps and impedance reference.
   input wire enhanced_i,
   input wire lat_opt_i,
   input wire zq_tied_i,
   input wire [9:0] zq_ohms_i,
   // Read request and data.
   input wire rd_req_i,
   input wire [7:0] rd_data_i,
   // Outputs.
   output reg [7:0] q_o,
   output reg q_valid_o,
   output reg echo_clock_true_o,
   output reg echo_clock_comp_o,
   output reg pll_locked_o,
   output reg [7:0] zq_code_o,
   output reg cal_pulse_o
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Every pin crosses into the system clock through two flip-flops.
   // Clock pins are treated as levels; their edges are found below.
   wire [16:0] s;
   scs_sync #(.W(17)) u_sync (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .d_i({kclk_i, kclk_n_i, oclk_i, oclk_n_i, pll_disable_n_i, rd_req_i, zq_tied_i,
            zq_ohms_i}),
      .q_o(s)
   );
   wire k_s = s[16];
   wire kn_s = s[15];
   wire c_s = s[14];
   wire cn_s = s[13];
   wire en_s = s[12];
   wire req_s = s[11];
   wire zt_s = s[10];
   wire [9:0] zo_s = s[9:0];
   // Straps and read data come from pins as well, so they are synchronised too.
   // The data must be held steady around the request edge for this to be safe.
   wire [9:0] t;
   scs_sync #(.W(10)) u_sync_data (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .d_i({enhanced_i, lat_opt_i, rd_data_i}),
      .q_o(t)
   );
   wire enh_s = t[9];
   wire opt_s = t[8];
   wire [7:0] rdd_s = t[7:0];

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   reg k_d_reg, kn_d_reg, c_d_reg, cn_d_reg;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         k_d_reg <= 1'b0;
         kn_d_reg <= 1'b0;
         c_d_reg <= 1'b0;
         cn_d_reg <= 1'b0;
      end else begin
         k_d_reg <= k_s;
         kn_d_reg <= kn_s;
         c_d_reg <= c_s;
         cn_d_reg <= cn_s;
      end
   end
   // Falling edges are only looked at on the output clock, to mark the pair as in use.
   wire k_rise = k_s & ~k_d_reg; // [RULE3]
   wire kn_rise = kn_s & ~kn_d_reg; // [RULE3]
   wire c_rise = c_s & ~c_d_reg;
   wire cn_rise = cn_s & ~cn_d_reg;
   // A strapped-high pin shows one false rise as the synchroniser leaves reset.
   // It never falls, so only a fall marks the output clock pair as in use.
   wire c_fall = ~c_s & c_d_reg;
   // Output clocks strapped high never toggle, so the pair counts as unused.
   reg c_used_reg;
   wire half_tick = c_used_reg ? (c_rise | cn_rise) : (k_rise | kn_rise); // [RULE6]

   // ----------------------------------------------------------------
   // PLL enable and lock
   // ----------------------------------------------------------------
   reg [7:0] lock_cnt_reg;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lock_cnt_reg <= 8'h00;
         pll_locked_o <= 1'b0;
      end else if (!en_s) begin
         lock_cnt_reg <= 8'h00; // [RULE12]
         pll_locked_o <= 1'b0;
      end else if (k_rise && !pll_locked_o) begin
         lock_cnt_reg <= lock_cnt_reg + 8'h01;
         pll_locked_o <= (lock_cnt_reg == `SCS_LOCK_CYC - 8'h01);
      end
   end
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         c_used_reg <= 1'b0;
      end else if (c_fall && !c_used_reg) begin
         c_used_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Read pipeline and echo clocks
   // ----------------------------------------------------------------
   reg [2:0] lat;
   always @* begin
      if (!enh_s) begin
         lat = `SCS_LAT_BASE; // [RULE15]
      end else if (opt_s) begin
         lat = `SCS_LAT_ENH_B;
      end else begin
         lat = `SCS_LAT_ENH_A;
      end
   end
   // Bit n of the pipeline is set n half ticks after the request edge.
   // A request is only shifted in while locked, so early requests are dropped.
   reg [5:0] pipe_reg;
   reg [7:0] data_hold_reg;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pipe_reg <= 6'h00;
         data_hold_reg <= 8'h00;
         q_o <= 8'h00;
         q_valid_o <= 1'b0;
         echo_clock_true_o <= 1'b0;
         echo_clock_comp_o <= 1'b1;
      end else begin
         if (k_rise) begin
            data_hold_reg <= rdd_s; // [RULE3]
         end
         if (half_tick && pll_locked_o) begin
            pipe_reg <= {pipe_reg[4:0], k_rise & req_s};
            // Echo pair toggles in the same cycle as the data launch.
            echo_clock_true_o <= ~echo_clock_true_o; // [RULE7] [RULE8]
            echo_clock_comp_o <= echo_clock_true_o; // [RULE7]
            // Reading tap lat-1 launches the data on the lat-th half tick.
            q_valid_o <= pipe_reg[lat - `SCS_LAT_OFS]; // [RULE15] [RULE6]
            if (pipe_reg[lat - `SCS_LAT_OFS]) begin
               q_o <= data_hold_reg; // [RULE6]
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Impedance calibration
   // ----------------------------------------------------------------
   reg [11:0] cal_cnt_reg;
   // The interval counts link clock rises from reset, locked or not, so the
   // driver keeps tracking drift even while the PLL is held off.
   wire [11:0] cal_top = enh_s ? `SCS_CAL_ENH : `SCS_CAL_BASE;
   wire [9:0] zraw = zo_s / {2'b00, `SCS_Z_DIV}; // [RULE2]
   reg [7:0] zcalc;
   always @* begin
      if (zt_s || zraw < {2'b00, `SCS_Z_MIN}) begin
         zcalc = `SCS_Z_MIN; // [RULE2]
      end else if (zraw > {2'b00, `SCS_Z_MAX}) begin
         zcalc = `SCS_Z_MAX;
      end else begin
         zcalc = zraw[7:0];
      end
   end
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cal_cnt_reg <= 12'h000;
         cal_pulse_o <= 1'b0;
         zq_code_o <= `SCS_Z_MIN;
      end else begin
         cal_pulse_o <= 1'b0;
         if (k_rise) begin
            if (cal_cnt_reg >= cal_top - 12'h001) begin
               cal_cnt_reg <= 12'h000; // [RULE1]
               cal_pulse_o <= 1'b1;
               zq_code_o <= zcalc;
            end else begin
               cal_cnt_reg <= cal_cnt_reg + 12'h001;
            end
         end
      end
   end
endmodule // scs_clocking
`default_nettype wire

//--- tb/scs_checker.sv
`default_nettype none
module scs_checker (
   input wire logic mclk_i, arst_n_i, pll_disable_n_i, q_valid_o, pll_locked_o,
   input wire logic echo_clock_true_o, echo_clock_comp_o, cal_pulse_o,
   input wire logic [7:0] q_o, zq_code_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   echo_pair_a: assert property (echo_clock_comp_o == !echo_clock_true_o)
      else $error("echo pair not complementary");
   pll_off_a: assert property (!pll_disable_n_i [*4] |-> !pll_locked_o)
      else $error("lock held while disabled");
   valid_locked_a: assert property ($rose(q_valid_o) |-> pll_locked_o)
      else $error("data without lock");
   echo_hold_a: assert property ($changed(echo_clock_true_o) |=> $stable(echo_clock_true_o) [*2])
      else $error("echo toggles too fast");
   zq_range_a: assert property (zq_code_o >= 8'h23 && zq_code_o <= 8'h46)
      else $error("impedance out of range");
   cal_single_a: assert property (cal_pulse_o |=> !cal_pulse_o [*8])
      else $error("calibration pulses too close");
   valid_width_a: assert property ($rose(q_valid_o) |-> q_valid_o [*3] ##[1:3] !q_valid_o)
      else $error("valid width wrong");
   data_valid_a: assert property ($changed(q_o) |-> $rose(q_valid_o))
      else $error("data moved without valid");
endmodule // scs_checker
bind scs_clocking scs_checker u_chk (.*);
`default_nettype wire

//--- tb/scs_ctrl_model.sv
`default_nettype none
module scs_ctrl_model (
   input wire logic mclk_i, start_i, use_oclk_i,
   output logic kclk_o, kclk_n_o, oclk_o, oclk_n_o, pll_disable_n_o, ready_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int unsigned wait_cnt;
   initial kclk_o = 1'b0;
   initial pll_disable_n_o = 1'b0;
   // A 5 MHz link clock stays far below the input clock capture limit.
   always #100 kclk_o = !kclk_o;
   assign kclk_n_o = !kclk_o;
   // Output clocks follow the input pair when used, else they are strapped high.
   assign oclk_o = use_oclk_i ? kclk_o : 1'b1;
   assign oclk_n_o = use_oclk_i ? !kclk_o : 1'b1;
   // The wait of 20 us is exactly 800 cycles of 25 ns.
   always @(posedge mclk_i) begin
      pll_disable_n_o <= start_i;
      wait_cnt <= start_i ? wait_cnt + (wait_cnt < 800) : 0;
   end
   assign ready_o = wait_cnt == 800;
endmodule // scs_ctrl_model
`default_nettype wire

//--- tb/scs_clocking_tb_top.sv
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module scs_clocking_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_i = 1'b0, arst_n_i = 1'b0, start = 1'b0, rdy, enhanced_i = 1'b0;
   logic lat_opt_i = 1'b0, zq_tied_i = 1'b0, rd_req_i = 1'b0, kclk_i, kclk_n_i, oclk_i;
   logic oclk_n_i, pll_disable_n_i, q_valid_o, echo_clock_true_o, echo_clock_comp_o;
   logic pll_locked_o, cal_pulse_o, use_oclk = 1'b0;
   logic [9:0] zq_ohms_i = 10'h0fa;
   logic [7:0] rd_data_i = 8'h00, q_o, zq_code_o;
   logic [15:0] rows [3] = '{16'h035a, 16'h243c, 16'h35c3};
   int err_count, total_checks, n, t0;
   scs_clocking u_dut (.*);
   scs_ctrl_model u_ctrl (.mclk_i(mclk_i), .start_i(start), .use_oclk_i(use_oclk), .kclk_o(kclk_i),
      .kclk_n_o(kclk_n_i), .oclk_o(oclk_i), .oclk_n_o(oclk_n_i),
      .pll_disable_n_o(pll_disable_n_i), .ready_o(rdy));
   always #12.5 mclk_i = !mclk_i;
   task automatic rd(input logic [15:0] r);
      @(negedge kclk_i);
      @(posedge mclk_i) #1;
      {enhanced_i, lat_opt_i} = r[13:12];
      rd_data_i = r[7:0];
      rd_req_i = 1'b1;
      @(posedge kclk_i);
      for (n = 0; n < 40 && !q_valid_o; n++) begin
         @(posedge mclk_i) #1;
         if (n == 6) rd_req_i = 1'b0;
      end
   endtask
   task wc;
      for (n = 0; n < 9000 && !cal_pulse_o; n++) @(posedge mclk_i) #1;
      if (n == 9000) begin
         err_count++;
         tally_and_finish;
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge mclk_i);
      #1 arst_n_i = 1'b1;
      rd(16'h0377);
      `CHK(n, 40)
      start = 1'b1;
      for (n = 0; n < 900 && !rdy; n++) @(posedge mclk_i) #1;
      `CHK(rdy, 1'b1)
      `CHK(pll_locked_o, 1'b1)
      foreach (rows[i]) begin
         rd(rows[i]);
         `CHK(q_o, rows[i][7:0])
         `CHK(n >= rows[i][11:8] * 4 + 1 && n <= rows[i][11:8] * 4 + 6, 1'b1)
      end
      // Drive the output clock pair; data must then follow it with the same latency.
      use_oclk = 1'b1;
      rd(rows[0]);
      `CHK(q_o, rows[0][7:0])
      `CHK(n >= 13 && n <= 18, 1'b1)
      // A new impedance only lands at a calibration pulse, so measure across two.
      wc;
      @(posedge mclk_i) #1;
      `CHK(zq_code_o, 8'h32)
      zq_tied_i = 1'b1;
      t0 = $time;
      wc;
      `CHK(($time - t0) / 25 + 1, 8192)
      @(posedge mclk_i) #1;
      `CHK(zq_code_o, 8'h23)
      // Dropping the PLL enable must lose lock within a few cycles.
      start = 1'b0;
      repeat (6) @(posedge mclk_i) #1;
      `CHK(pll_locked_o, 1'b0)
      arst_n_i = 1'b0;
      #5;
      `CHK({q_valid_o, pll_locked_o, echo_clock_comp_o, zq_code_o}, 11'h123)
      @(posedge mclk_i) #1;
      arst_n_i = 1'b1;
      repeat (2) @(posedge mclk_i) #1;
      `CHK({pll_locked_o, echo_clock_true_o, echo_clock_comp_o}, 3'h1)
      tally_and_finish;
   end
endmodule // scs_clocking_tb_top
`default_nettype wire
